// [hdl/pdp_pkg.sv]
package pdp_pkg;
	// ****************************************
	// Field widths.
	// ****************************************
	localparam int M_W = 9;
	localparam int R_W = 6;
	localparam int A_W = 4;
	localparam int CFG_W = 1 + M_W + R_W + A_W;
	// ****************************************
	// Byte field positions.
	// ****************************************
	localparam int B1_PRE = 7;
	localparam int B1_M_HI = 6;
	localparam int B2_R_HI = 3;
	localparam int B2_R_LO = 2;
	localparam int B2_M_HI = 1;
	localparam int B3_R_HI = 7;
	localparam int B3_R_LO = 4;
	localparam int B3_A_HI = 3;
	// ****************************************
	// Reset values, direct pin and sync widths, and prescaler modulus.
	// ****************************************
	localparam logic [CFG_W-1:0] CFG_RST = 20'h80000;
	localparam int DM_W = 7;
	localparam int DR_W = 4;
	localparam int SYNC_W = 8;
	localparam int PRE_MOD = 10;
	// ****************************************
	// Programming modes.
	// ****************************************
	typedef enum logic [1:0] {
		PDP_BUS = 2'b00,
		PDP_SERIAL = 2'b01,
		PDP_DIRECT = 2'b10
	} pdp_mode_e;
endpackage

// [hdl/pdp_program_port.sv]
`timescale 1ns/1ns
module pdp_program_port (
	// Clock and reset.
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Mode pins.
	input wire logic parallel_port_select_n_in,
	input wire logic serial_link_select_in,
	input wire logic legacy_compat_select_in,
	// Byte bus.
	input wire logic [7:0] host_byte_lines_in,
	input wire logic main_count_low_strobe_in,
	input wire logic upper_bits_strobe_in,
	input wire logic ref_swallow_strobe_in,
	input wire logic transfer_strobe_in,
	input wire logic bank_select_parallel_in,
	// Serial link.
	input wire logic serial_in,
	input wire logic shift_enable_n_in,
	input wire logic shift_clk_in,
	input wire logic bank_select_serial_in,
	// Direct pins.
	input wire logic [pdp_pkg::DM_W-1:0] direct_main_in,
	input wire logic [pdp_pkg::A_W-1:0] direct_swallow_in,
	input wire logic [pdp_pkg::DR_W-1:0] direct_ref_in,
	input wire logic direct_prescaler_dis_in,
	// Divider settings.
	output logic prescaler_on_out,
	output logic [pdp_pkg::M_W-1:0] main_count_out,
	output logic [pdp_pkg::R_W-1:0] ref_count_out,
	output logic [pdp_pkg::A_W-1:0] swallow_count_out,
	output logic [6:0] ref_ratio_out,
	output logic [13:0] feedback_ratio_out
);
	// ****************************************
	// Local positions and reset images.
	// ****************************************
	localparam int R_LO = pdp_pkg::A_W;
	localparam int M_LO = pdp_pkg::A_W + pdp_pkg::R_W;
	localparam int PRE_POS = pdp_pkg::CFG_W - 1;
	localparam int M_HI_W = pdp_pkg::M_W - pdp_pkg::DM_W;
	localparam int R_HI_W = pdp_pkg::R_W - pdp_pkg::DR_W;
	localparam int RAT_W = pdp_pkg::R_W + 1;
	localparam int MI_W = pdp_pkg::M_W + 1;
	localparam int FB_W = $bits(feedback_ratio_out);
	localparam int CTL_W = 5;
	localparam int CTL_BP = 0;
	localparam int CTL_BS = 1;
	localparam int CTL_BUSN = 2;
	localparam int CTL_SER = 3;
	localparam int CTL_LEG = 4;
	localparam int STB_W = 4;
	localparam int STB_M1 = 0;
	localparam int STB_M2 = 1;
	localparam int STB_AW = 2;
	localparam int STB_XF = 3;
	localparam int LNK_W = 3;
	localparam int LNK_DAT = 0;
	localparam int LNK_SEN = 1;
	localparam int LNK_CLK = 2;
	localparam logic [LNK_W-1:0] LNK_IDLE = 3'h2;
	localparam int DIR_W = 1 + pdp_pkg::DM_W + pdp_pkg::A_W + pdp_pkg::DR_W;
	localparam logic [M_HI_W-1:0] M_HI_ZERO = '0;
	localparam logic [R_HI_W-1:0] R_HI_ZERO = '0;
	localparam logic RST_PRE = pdp_pkg::CFG_RST[PRE_POS];
	localparam logic [pdp_pkg::M_W-1:0] RST_M =
		pdp_pkg::CFG_RST[M_LO +: pdp_pkg::M_W];
	localparam logic [pdp_pkg::R_W-1:0] RST_R =
		pdp_pkg::CFG_RST[R_LO +: pdp_pkg::R_W];
	localparam logic [pdp_pkg::A_W-1:0] RST_A =
		pdp_pkg::CFG_RST[pdp_pkg::A_W-1:0];
	localparam logic [RAT_W-1:0] RST_RAT = RAT_W'(RST_R) + RAT_W'(1);
	localparam logic [FB_W-1:0] RST_FB =
		FB_W'(pdp_pkg::PRE_MOD * (int'(RST_M) + 1) + int'(RST_A));
	// ****************************************
	// Declarations.
	// ****************************************
	logic [CTL_W-1:0] ctl_pin_w, ctl_meta_r, ctl_sync_r;
	logic [STB_W-1:0] strb_pin_w, strb_meta_r, strb_sync_r, strb_prev_r;
	logic [STB_W-1:0] strb_rise_w;
	logic [LNK_W-1:0] lnk_pin_w, lnk_meta_r, lnk_sync_r, lnk_prev_r;
	logic [7:0] byte_meta_r, byte_sync_r;
	logic [DIR_W-1:0] dir_pin_w, dir_meta_r, dir_sync_r;
	logic [pdp_pkg::DM_W-1:0] dir_main_w;
	logic [pdp_pkg::A_W-1:0] dir_swal_w;
	logic [pdp_pkg::DR_W-1:0] dir_ref_w;
	logic dir_dis_w;
	logic [1:0] mode_code_w;
	logic is_bus_w, is_ser_w, is_dir_w;
	logic sclk_rise_w, sen_rise_w;
	logic main_count_low_byte_w, high_bits_nibble_w, a_wr_w, shift_w, copy_w;
	logic [pdp_pkg::CFG_W-1:0] prim_cfg_r, prim_cfg_nxt;
	logic [pdp_pkg::CFG_W-1:0] sec_cfg_r, sec_cfg_nxt, bank_w;
	logic pm_pre_w, pre_nxt_w, bk_pre_w, sel_pre_w, use_prim_w;
	logic [pdp_pkg::M_W-1:0] pm_m_w, m_nxt_w, bk_m_w, sel_m_w;
	logic [pdp_pkg::R_W-1:0] pm_rf_w, rf_nxt_w, bk_rf_w, sel_rf_w;
	logic [pdp_pkg::A_W-1:0] pm_a_w, a_nxt_w, bk_a_w, sel_a_w;
	logic [MI_W-1:0] m_inc_w;
	logic [RAT_W-1:0] ratio_nxt_w, ratio_r;
	logic [FB_W-1:0] fb_nxt_w, fb_r;
	logic pre_on_r;
	logic [pdp_pkg::M_W-1:0] main_r;
	logic [pdp_pkg::R_W-1:0] ref_r;
	logic [pdp_pkg::A_W-1:0] swal_r;
	// ****************************************
	// Pin synchronisers.
	// ****************************************
	assign ctl_pin_w = {legacy_compat_select_in, serial_link_select_in,
		parallel_port_select_n_in, bank_select_serial_in,
		bank_select_parallel_in};
	assign strb_pin_w = {transfer_strobe_in, ref_swallow_strobe_in,
		upper_bits_strobe_in, main_count_low_strobe_in};
	assign lnk_pin_w = {shift_clk_in, shift_enable_n_in, serial_in};
	assign dir_pin_w = {direct_prescaler_dis_in, direct_main_in,
		direct_swallow_in, direct_ref_in};
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctl_meta_r <= '0;
			ctl_sync_r <= '0;
			byte_meta_r <= '0;
			byte_sync_r <= '0;
			dir_meta_r <= '0;
			dir_sync_r <= '0;
		end else begin
			ctl_meta_r <= ctl_pin_w;
			ctl_sync_r <= ctl_meta_r;
			byte_meta_r <= host_byte_lines_in;
			byte_sync_r <= byte_meta_r;
			dir_meta_r <= dir_pin_w;
			dir_sync_r <= dir_meta_r;
		end
	end
	// Edge pins reset to their idle levels so no false edge follows reset.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			strb_meta_r <= '0;
			strb_sync_r <= '0;
			strb_prev_r <= '0;
			lnk_meta_r <= LNK_IDLE;
			lnk_sync_r <= LNK_IDLE;
			lnk_prev_r <= LNK_IDLE;
		end else begin
			strb_meta_r <= strb_pin_w;
			strb_sync_r <= strb_meta_r;
			strb_prev_r <= strb_sync_r;
			lnk_meta_r <= lnk_pin_w;
			lnk_sync_r <= lnk_meta_r;
			lnk_prev_r <= lnk_sync_r;
		end
	end
	// ****************************************
	// Mode decode and edges.
	// ****************************************
	assign mode_code_w = {ctl_sync_r[CTL_BUSN],
		~ctl_sync_r[CTL_BUSN] & ctl_sync_r[CTL_SER]};
	assign is_bus_w = (mode_code_w == pdp_pkg::PDP_BUS);
	assign is_ser_w = (mode_code_w == pdp_pkg::PDP_SERIAL);
	assign is_dir_w = (mode_code_w == pdp_pkg::PDP_DIRECT);
	assign strb_rise_w = strb_sync_r & ~strb_prev_r;
	assign sclk_rise_w = lnk_sync_r[LNK_CLK] & ~lnk_prev_r[LNK_CLK];
	assign sen_rise_w = lnk_sync_r[LNK_SEN] & ~lnk_prev_r[LNK_SEN];
	assign main_count_low_byte_w = is_bus_w & strb_rise_w[STB_M1];
	assign high_bits_nibble_w = is_bus_w & strb_rise_w[STB_M2];
	assign a_wr_w = is_bus_w & strb_rise_w[STB_AW];
	assign shift_w = is_ser_w & sclk_rise_w & ~lnk_sync_r[LNK_SEN];
	assign copy_w = (strb_rise_w[STB_XF] & (is_bus_w | is_ser_w)) |
		(sen_rise_w & is_ser_w);
	// ****************************************
	// Primary and secondary registers.
	// ****************************************
	assign pm_pre_w = prim_cfg_r[PRE_POS];
	assign pm_m_w = prim_cfg_r[M_LO +: pdp_pkg::M_W];
	assign pm_rf_w = prim_cfg_r[R_LO +: pdp_pkg::R_W];
	assign pm_a_w = prim_cfg_r[pdp_pkg::A_W-1:0];
	assign pre_nxt_w = main_count_low_byte_w ? byte_sync_r[pdp_pkg::B1_PRE] : pm_pre_w;
	assign m_nxt_w = {
		high_bits_nibble_w ? byte_sync_r[pdp_pkg::B2_M_HI:0] :
			pm_m_w[pdp_pkg::M_W-1:pdp_pkg::DM_W],
		main_count_low_byte_w ? byte_sync_r[pdp_pkg::B1_M_HI:0] :
			pm_m_w[pdp_pkg::DM_W-1:0]};
	assign rf_nxt_w = {
		high_bits_nibble_w ? byte_sync_r[pdp_pkg::B2_R_HI:pdp_pkg::B2_R_LO] :
			pm_rf_w[pdp_pkg::R_W-1:pdp_pkg::DR_W],
		a_wr_w ? byte_sync_r[pdp_pkg::B3_R_HI:pdp_pkg::B3_R_LO] :
			pm_rf_w[pdp_pkg::DR_W-1:0]};
	assign a_nxt_w = a_wr_w ? byte_sync_r[pdp_pkg::B3_A_HI:0] : pm_a_w;
	assign prim_cfg_nxt = shift_w ?
		{prim_cfg_r[PRE_POS-1:0], lnk_sync_r[LNK_DAT]} :
		{pre_nxt_w, m_nxt_w, rf_nxt_w, a_nxt_w};
	assign sec_cfg_nxt = copy_w ? prim_cfg_r : sec_cfg_r;
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prim_cfg_r <= pdp_pkg::CFG_RST;
			sec_cfg_r <= pdp_pkg::CFG_RST;
		end else begin
			prim_cfg_r <= prim_cfg_nxt;
			sec_cfg_r <= sec_cfg_nxt;
		end
	end
	// ****************************************
	// Divider setting selection.
	// ****************************************
	assign dir_ref_w = dir_sync_r[pdp_pkg::DR_W-1:0];
	assign dir_swal_w = dir_sync_r[pdp_pkg::DR_W +: pdp_pkg::A_W];
	assign dir_main_w =
		dir_sync_r[pdp_pkg::DR_W+pdp_pkg::A_W +: pdp_pkg::DM_W];
	assign dir_dis_w = dir_sync_r[DIR_W-1];
	assign use_prim_w = is_bus_w ? ctl_sync_r[CTL_BP] :
		ctl_sync_r[CTL_BS];
	assign bank_w = use_prim_w ? prim_cfg_r : sec_cfg_r;
	assign bk_pre_w = bank_w[PRE_POS];
	assign bk_m_w = bank_w[M_LO +: pdp_pkg::M_W];
	assign bk_rf_w = bank_w[R_LO +: pdp_pkg::R_W];
	assign bk_a_w = bank_w[pdp_pkg::A_W-1:0];
	assign sel_m_w = is_dir_w ? {M_HI_ZERO, dir_main_w} : {
		ctl_sync_r[CTL_LEG] ? bk_m_w[pdp_pkg::M_W-1:pdp_pkg::DM_W] :
			M_HI_ZERO, bk_m_w[pdp_pkg::DM_W-1:0]};
	assign sel_rf_w = is_dir_w ? {R_HI_ZERO, dir_ref_w} : {
		ctl_sync_r[CTL_LEG] ? bk_rf_w[pdp_pkg::R_W-1:pdp_pkg::DR_W] :
			R_HI_ZERO, bk_rf_w[pdp_pkg::DR_W-1:0]};
	assign sel_a_w = is_dir_w ? dir_swal_w : bk_a_w;
	assign sel_pre_w = is_dir_w ? dir_dis_w : bk_pre_w;
	assign ratio_nxt_w = RAT_W'(sel_rf_w) + RAT_W'(1);
	assign m_inc_w = MI_W'(sel_m_w) + MI_W'(1);
	assign fb_nxt_w =
		FB_W'(pdp_pkg::PRE_MOD * int'(m_inc_w) + int'(sel_a_w));
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pre_on_r <= ~RST_PRE;
			main_r <= RST_M;
			ref_r <= RST_R;
			swal_r <= RST_A;
			ratio_r <= RST_RAT;
			fb_r <= RST_FB;
		end else begin
			pre_on_r <= ~sel_pre_w;
			main_r <= sel_m_w;
			ref_r <= sel_rf_w;
			swal_r <= sel_a_w;
			ratio_r <= ratio_nxt_w;
			fb_r <= fb_nxt_w;
		end
	end
	assign prescaler_on_out = pre_on_r;
	assign main_count_out = main_r;
	assign ref_count_out = ref_r;
	assign swallow_count_out = swal_r;
	assign ref_ratio_out = ratio_r;
	assign feedback_ratio_out = fb_r;
	// ****************************************
	// Assertions.
	// ****************************************
	property p_m1_load;
		@(posedge core_clk_in) disable iff (!resetn_in)
		main_count_low_byte_w |=> pm_m_w[pdp_pkg::DM_W-1:0] ==
			$past(byte_sync_r[pdp_pkg::B1_M_HI:0]) &&
			pm_pre_w == $past(byte_sync_r[pdp_pkg::B1_PRE]);
	endproperty
	a_m1_load: assert property (p_m1_load)
		else $error("main low byte not loaded");
	property p_m2_load;
		@(posedge core_clk_in) disable iff (!resetn_in)
		high_bits_nibble_w |=> pm_m_w[pdp_pkg::M_W-1:pdp_pkg::DM_W] ==
			$past(byte_sync_r[pdp_pkg::B2_M_HI:0]) &&
			pm_rf_w[pdp_pkg::R_W-1:pdp_pkg::DR_W] ==
			$past(byte_sync_r[pdp_pkg::B2_R_HI:pdp_pkg::B2_R_LO]);
	endproperty
	a_m2_load: assert property (p_m2_load)
		else $error("upper bits not loaded");
	property p_a_load;
		@(posedge core_clk_in) disable iff (!resetn_in)
		a_wr_w |=> pm_a_w == $past(byte_sync_r[pdp_pkg::B3_A_HI:0]) &&
			pm_rf_w[pdp_pkg::DR_W-1:0] ==
			$past(byte_sync_r[pdp_pkg::B3_R_HI:pdp_pkg::B3_R_LO]);
	endproperty
	a_a_load: assert property (p_a_load)
		else $error("reference and swallow byte not loaded");
	property p_shift;
		@(posedge core_clk_in) disable iff (!resetn_in)
		shift_w |=> prim_cfg_r[0] == $past(lnk_sync_r[LNK_DAT]) &&
			prim_cfg_r[PRE_POS] == $past(prim_cfg_r[PRE_POS-1]);
	endproperty
	a_shift: assert property (p_shift)
		else $error("serial bit not shifted in");
	property p_copy;
		@(posedge core_clk_in) disable iff (!resetn_in)
		copy_w |=> sec_cfg_r == $past(prim_cfg_r);
	endproperty
	a_copy: assert property (p_copy)
		else $error("primary not copied to secondary");
	property p_hold;
		@(posedge core_clk_in) disable iff (!resetn_in)
		!copy_w |=> $stable(sec_cfg_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("secondary changed without transfer");
	property p_legacy;
		@(posedge core_clk_in) disable iff (!resetn_in)
		!ctl_sync_r[CTL_LEG] |=>
			main_count_out[pdp_pkg::M_W-1:pdp_pkg::DM_W] == M_HI_ZERO &&
			ref_count_out[pdp_pkg::R_W-1:pdp_pkg::DR_W] == R_HI_ZERO;
	endproperty
	a_legacy: assert property (p_legacy)
		else $error("upper bits not forced low");
	property p_direct;
		@(posedge core_clk_in) disable iff (!resetn_in)
		is_dir_w |=> main_count_out[pdp_pkg::DM_W-1:0] ==
			$past(dir_main_w) && swallow_count_out == $past(dir_swal_w) &&
			ref_count_out[pdp_pkg::DR_W-1:0] == $past(dir_ref_w);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct pins not routed");
	property p_bank;
		@(posedge core_clk_in) disable iff (!resetn_in)
		is_bus_w && ctl_sync_r[CTL_BP] |=>
			swallow_count_out == $past(pm_a_w);
	endproperty
	a_bank: assert property (p_bank)
		else $error("primary bank not selected");
endmodule

// [verification/pdp_host_model.sv]
`timescale 1ns/1ns
module pdp_host_model(input wire logic go, output logic shift_clk_in=0,
	output logic serial_in=0, output logic shift_enable_n_in=1);
	always @(posedge go) begin shift_enable_n_in=0;
		repeat(20) begin serial_in=~serial_in; #24 shift_clk_in=1;
			#24 shift_clk_in=0; end shift_enable_n_in=1; end
endmodule

// [verification/pdp_program_port_tb.sv]
`timescale 1ns/1ns
module pdp_program_port_tb;
	logic core_clk_in=0, resetn_in=0, go=0, parallel_port_select_n_in=0;
	logic serial_link_select_in=0, legacy_compat_select_in=1;
	logic bank_select_parallel_in=1, bank_select_serial_in=0;
	logic [3:0] stb=0; logic [7:0] host_byte_lines_in=0;
	wire main_count_low_strobe_in=stb[0], upper_bits_strobe_in=stb[1];
	wire ref_swallow_strobe_in=stb[2], transfer_strobe_in=stb[3];
	wire serial_in, shift_enable_n_in, shift_clk_in; wire [40:0] o;
	int mismatches=0, n_tests=0;
	logic [23:0] rows[3]='{24'h7e0079, 24'h010000, 24'h810ff0};
	pdp_host_model u_host(.*);
	logic [23:0] dv=0;
	pdp_program_port u_dut(.*, .direct_main_in(dv[22:16]),
		.direct_ref_in(dv[7:4]), .direct_swallow_in(dv[3:0]),
		.direct_prescaler_dis_in(dv[23]),
		.prescaler_on_out(o[40]), .main_count_out(o[39:31]),
		.ref_count_out(o[30:25]), .swallow_count_out(o[24:21]),
		.ref_ratio_out(o[20:14]), .feedback_ratio_out(o[13:0]));
	task w; repeat(8) @(posedge core_clk_in); endtask
	task st(int k, logic [7:0] v); host_byte_lines_in<=v; stb[k]<=1; w;
		stb[k]<=0; w; endtask
	task c(logic [23:0] b); logic [8:0] m; logic [5:0] r; logic [40:0] e;
		m={b[9:8],b[22:16]}; r={b[11:10],b[7:4]}; w; n_tests++;
		e={~b[23],m,r,b[3:0],7'(r+1),14'(10*(m+1)+b[3:0])};
		if (o!==e) $display("unexpected %0t %h %h", $time, o, e);
		mismatches+=(o!==e); endtask
	task test_done; $display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (!mismatches && n_tests) $display("Test passed");
		else $display("Test failed");
		$finish; endtask
	initial forever #2 core_clk_in=~core_clk_in;
	initial begin repeat(2) @(posedge core_clk_in); resetn_in<=1; w;
		c(24'h800000);
		foreach (rows[i]) begin st(0, rows[i][23:16]); st(1, rows[i][15:8]);
			st(2, rows[i][7:0]); c(rows[i]); end
		st(3, 0); bank_select_parallel_in<=0; c(24'h810ff0);
		st(0, 8'h7e); c(24'h810ff0);
		bank_select_parallel_in<=1; legacy_compat_select_in<=0; c(24'h7e00f0);
		serial_link_select_in<=1; c(24'h8100f0); go<=1;
		repeat(32) w; c(24'haa00aa);
		bank_select_serial_in<=1; c(24'haa00aa);
		dv<=24'h350097; parallel_port_select_n_in<=1; c(24'h350097);
		test_done; end
endmodule
